// [bench/clkgen_asserts.sv]
// Assertions for the clock prescaler block
`timescale 1ns/1ns
`include "clkgen_cfg.svh"
module clkgen_asserts (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Mode, wake and taps
  input wire clkgen_pkg::power_mode_t power_mode_i,
  input wire logic wake_accept_i,
  input wire logic osc_run_o,
  input wire logic hold_idle_o,
  input wire logic wake_done_o,
  input wire logic port3_bit1_pin_en_o,
  input wire clkgen_pkg::clk_taps_t taps_o,
  input wire logic sys_tick_o,
  input wire logic subclk_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic stop; // System clock halted
  logic wr; // Byte write taken
  logic [17:0] idle_cnt;
  logic [17:0] next_idle_cnt;
  assign stop = power_mode_i >= clkgen_pkg::MODE_STANDBY;
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  ////////////////////////////////////////////////////////////
  // Idle cycles since the oscillator restarted
  always_comb begin
    next_idle_cnt = (hold_idle_o && osc_run_o && !rst_i) ? idle_cnt + 18'h1 : 18'h0;
  end
  always_ff @(posedge clk_i) begin
    idle_cnt <= next_idle_cnt;
  end
  // Timer A mode write with both clear bits
  sequence clr_write;
    wr && adr_i == `OFS_TMRA_MODE && dat_i[3:2] == 2'h3 ##1 ack_o;
  endsequence
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack stuck");
  a_sys_count: assert property (
    sys_tick_o && !hold_idle_o && !stop |=> taps_o.sys == $past(taps_o.sys) + 13'h1)
    else $error("sys prescaler step");
  a_sys_zero: assert property (stop ##1 stop |-> taps_o.sys == 13'h0)
    else $error("sys prescaler not zero");
  a_sub_step: assert property (
    subclk_tick_o ##1 !ack_o |-> taps_o.watch[7:3] == $past(taps_o.watch[7:3]) + 5'h1)
    else $error("sub prescaler step");
  a_sub_clear: assert property (clr_write |-> taps_o.watch[7:3] == 5'h0)
    else $error("sub prescaler not cleared");
  a_pin_select: assert property (
    wr && adr_i == `OFS_PORTMODE2 |=> port3_bit1_pin_en_o == !$past(dat_i[7]))
    else $error("pin enable wrong");
  a_stop_idle: assert property (!hold_idle_o && stop |=> hold_idle_o && !osc_run_o)
    else $error("no halt on stop");
  a_wake_start: assert property (!osc_run_o && wake_accept_i |=> osc_run_o)
    else $error("oscillator not restarted");
  a_done_run: assert property (wake_done_o |=> !hold_idle_o)
    else $error("idle after wait");
  a_wait_min: assert property (wake_done_o |-> idle_cnt >= 18'h8)
    else $error("wait too short");
  // The watch /2 and /4 taps wrap to zero with each prescaler step
  a_watch_tap: assert property (subclk_tick_o |=> taps_o.watch[2:1] == 2'h0)
    else $error("watch taps not wrapped");
endmodule // clkgen_asserts
bind clock_prescalers_and_wake_wait clkgen_asserts chk_u (.*);

// [bench/clock_prescalers_and_wake_wait_tb.sv]
// Self-checking bench for the clock prescaler block
`timescale 1ns/1ns
`include "clkgen_cfg.svh"
module clock_prescalers_and_wake_wait_tb;
  // Design inputs, set at time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  clkgen_pkg::power_mode_t power_mode_i = clkgen_pkg::MODE_ACTIVE_HS;
  logic wake_accept_i = 1'b0;
  logic osc_stable_i = 1'b1;
  logic sub_osc_in_i;
  logic ext_subclk_i;
  // Design outputs
  logic [31:0] dat_o;
  logic ack_o;
  logic osc_run_o;
  logic hold_idle_o;
  logic wake_done_o;
  logic port3_bit1_pin_en_o;
  clkgen_pkg::clk_taps_t taps_o;
  logic sys_tick_o;
  logic subclk_tick_o;
  // Bench state
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [12:0] s0;
  int g;
  int n;
  ////////////////////////////////////////////////////////////
  always #10 clk_i = !clk_i;
  clock_prescalers_and_wake_wait dut_u (.*);
  subclk_source src_u (.xt_o(sub_osc_in_i), .ext_o(ext_subclk_i));
  ////////////////////////////////////////////////////////////
  // Wait length in states for a select value
  function automatic int wlen(input int s);
    return 8 << (2 * s);
  endfunction
  // Bench cycles between subclock prescaler steps
  function automatic int sgap(input int half);
    return half * 8 / 20;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    // Read data stands with ack at this same edge; release only now
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  // Cycles between two pulses of a tick output
  task automatic gap_of(input logic sub, output int cnt);
    cnt = 0;
    do @(negedge clk_i); while ((sub ? subclk_tick_o : sys_tick_o) !== 1'b1);
    do begin
      @(negedge clk_i);
      cnt++;
    end while ((sub ? subclk_tick_o : sys_tick_o) !== 1'b1);
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(20));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Both prescalers come out of reset at zero, then the system one counts
    @(negedge clk_i);
    check("sys reset", taps_o.sys, 32'h0);
    check("sub reset", taps_o.watch[7:3], 32'h0);
    @(negedge clk_i);
    check("sys start", taps_o.sys, 32'h1);
    wb(1'b0, `OFS_SYSCTL1, 32'h0);
    check("sysctl1", rd, 32'h70);
    wb(1'b1, `OFS_STATUS, 32'hffffffff);
    wb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd & 32'hffff07ff, 32'h18);
    repeat (4) begin
      wb(1'b0, 8'h10 + 8'($urandom_range(0, 59)) * 8'h4, 32'h0);
      check("unmapped", rd, 32'h0);
    end
    $display("registers done");
    // Long random span crosses the wrap point
    n = $urandom_range(8200, 9000);
    @(negedge clk_i);
    s0 = taps_o.sys;
    repeat (n) @(negedge clk_i);
    check("sys wrap", taps_o.sys, s0 + 13'(n));
    $display("wrap done");
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, `OFS_SYSCTL1, 32'(s));
      power_mode_i <= clkgen_pkg::MODE_ACTIVE_MS;
      gap_of(1'b0, g);
      gap_of(1'b0, g);
      check("ms gap", g, 32'h10 << s);
    end
    $display("medium speed done");
    // Resonator while active, external pin while stopped
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, `OFS_PORTMODE2, 32'(e) << 7);
      power_mode_i <= e ? clkgen_pkg::MODE_STANDBY : clkgen_pkg::MODE_ACTIVE_HS;
      osc_stable_i <= !e;
      n = sgap(e ? 605 : 205);
      check("pin en", port3_bit1_pin_en_o, !e);
      gap_of(1'b1, g);
      gap_of(1'b1, g);
      check("sub gap", g > n - 2 && g < n + 2, 1'b1);
    end
    check("stopped", {taps_o.sys, osc_run_o, hold_idle_o}, 15'h1);
    wb(1'b1, `OFS_TMRA_MODE, 32'hc);
    check("sub clear", taps_o.watch[7:3], 32'h0);
    $display("subclock done");
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `OFS_SYSCTL1, 32'(k) << 4);
      power_mode_i <= clkgen_pkg::MODE_STANDBY;
      osc_stable_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wake_accept_i <= 1'b1;
      power_mode_i <= clkgen_pkg::MODE_ACTIVE_HS;
      @(posedge clk_i);
      wake_accept_i <= 1'b0;
      repeat ($urandom_range(1, 6)) @(posedge clk_i);
      osc_stable_i <= 1'b1;
      g = 0;
      do begin
        @(negedge clk_i);
        g++;
      end while (hold_idle_o === 1'b1);
      check("wait span", g > wlen(k) && g < wlen(k) + 6, 1'b1);
    end
    $display("wake done");
    close_out();
  end
endmodule // clock_prescalers_and_wake_wait_tb

// [bench/subclk_source.sv]
// Model of the two subclock sources: a resonator and an external clock
`timescale 1ns/1ns
module subclk_source #(
  parameter int XT_HALF = 205, // Resonator half period, ns
  parameter int EXT_HALF = 605 // External clock half period, ns
) (
  // Clock lines
  output logic xt_o,
  output logic ext_o
);
  // Both run free; odd half periods keep every other edge off the bench clock edges
  initial xt_o = 1'b0;
  initial ext_o = 1'b0;
  always #(XT_HALF) xt_o = !xt_o;
  always #(EXT_HALF) ext_o = !ext_o;
endmodule // subclk_source

// [core/clock_prescalers_and_wake_wait.sv]
// Clock prescalers, subclock source select and wake wait counter
`timescale 1ns/1ns
`include "clkgen_cfg.svh"

// Operation
// - System prescaler: 13-bit counter, one per clock
// - Reset clears system prescaler, counts after release
// - Stopped modes halt and zero system prescaler
// - System prescaler count not software accessible
// - All peripherals share taps, choose own ratio
// - Taps: system /2../8192, watch /1../128
// - Medium speed feeds oscillator /16,/32,/64,/128
// - Subclock prescaler: 5-bit, clocked watch/4
// - Reset clears subclock prescaler, counts after release
// - Subclock prescaler runs in all low-power modes
// - Timer A mode bits 3,2 both one clear it
// - Subclock prescaler taps feed timer A time base
// - Select bit picks resonator or external clock
// - Select one blocks resonator, takes port pin function away
// - Wait length chosen by control bits 6:4
// - Hold idle 8 to 131072 states after wake, once the oscillator is stable
// - Wake restarts oscillator, then applies wait
module clock_prescalers_and_wake_wait (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power mode and wake
  input wire clkgen_pkg::power_mode_t power_mode_i,
  input wire logic wake_accept_i,
  input wire logic osc_stable_i,
  output logic osc_run_o,
  output logic hold_idle_o,
  output logic wake_done_o,
  // Subclock pins
  input wire logic sub_osc_in_i,
  input wire logic ext_subclk_i,
  output logic port3_bit1_pin_en_o,
  // Clock taps and enables
  output clkgen_pkg::clk_taps_t taps_o,
  output logic sys_tick_o,
  output logic subclk_tick_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] system_control_one;   // Wait select and medium divide select
  logic [7:0] timer_a_mode_reg;     // Timer A mode image
  logic [7:0] port_mode_reg_two;    // Subclock source select
  logic [7:0] next_system_control_one;
  logic [7:0] next_timer_a_mode_reg;
  logic [7:0] next_port_mode_reg_two;
  logic [31:0] next_dat;
  logic next_ack;
  logic [12:0] sysclk_prescaler;    // Never on the bus
  logic [12:0] next_sysclk_prescaler;
  logic [6:0] mdiv;                 // Medium-speed input divider
  logic [6:0] next_mdiv;
  logic [1:0] watch_div;            // Watch clock / 4 divider
  logic [1:0] next_watch_div;
  logic [4:0] subclk_prescaler;
  logic [4:0] next_subclk_prescaler;
  logic [17:0] wait_cnt;
  logic [17:0] next_wait_cnt;
  clkgen_pkg::wake_state_t wstate;
  clkgen_pkg::wake_state_t next_wstate;
  // Synchronisers: stage one feeds stage two only
  logic res_s1, res_s2, ext_s1, ext_s2, stb_s1, stb_s2;
  logic sub_prev;                   // Previous synced subclock level
  // Combinational helpers
  logic ext_subclock_select;
  logic sub_level;
  logic watch_tick;
  logic sys_tick;
  logic stop_mode;
  logic wr_en;
  logic tma_clear;
  logic [7:0] mdiv_ratio;
  logic [17:0] wait_len;
  logic [2:0] wake_wait_select;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Both subclock pins and the oscillator-good flag are asynchronous, so
  // nothing but the second stage may feed logic, or metastability leaks in
  always_ff @(posedge clk_i) begin
    res_s1 <= sub_osc_in_i;
    res_s2 <= res_s1;
    ext_s1 <= ext_subclk_i;
    ext_s2 <= ext_s1;
    stb_s1 <= osc_stable_i;
    stb_s2 <= stb_s1;
    sub_prev <= sub_level;
  end

  ////////////////////////////////////////////////////////////////////////
  // Subclock source and watch tick
  always_comb begin
    ext_subclock_select = port_mode_reg_two[`PORTMODE2_EXTSEL];
    // Only one source passes; resonator is ignored when external selected
    sub_level = ext_subclock_select ? ext_s2 : res_s2;
    watch_tick = sub_level & ~sub_prev;
    // Pin loses its port function while the external clock is used
    port3_bit1_pin_en_o = ~ext_subclock_select;
  end

  ////////////////////////////////////////////////////////////////////////
  // System clock enable
  always_comb begin
    stop_mode = (power_mode_i == clkgen_pkg::MODE_STANDBY) |
                (power_mode_i == clkgen_pkg::MODE_WATCH) |
                (power_mode_i == clkgen_pkg::MODE_SUBACTIVE) |
                (power_mode_i == clkgen_pkg::MODE_SUBSLEEP);
    mdiv_ratio = `MDIV_BASE <<
                 system_control_one[`SYSCTL1_MDIV_MSB:`SYSCTL1_MDIV_LSB];
    next_mdiv = 7'h00;
    sys_tick = 1'b0;
    if (stop_mode || wstate == clkgen_pkg::WK_STOPPED ||
        wstate == clkgen_pkg::WK_STARTUP) begin
      // Oscillator halted or still starting up: no system clock at all
      next_mdiv = 7'h00;
    end else if (power_mode_i == clkgen_pkg::MODE_ACTIVE_MS) begin
      // One enable every 16..128 oscillator cycles
      if ({1'b0, mdiv} == mdiv_ratio - 8'h01) begin
        sys_tick = 1'b1;
      end else begin
        next_mdiv = mdiv + 7'h01;
      end
    end else begin
      sys_tick = 1'b1;
    end
    sys_tick_o = sys_tick;
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler next values
  always_comb begin
    // Both taps groups are plain counter bits, shared by every peripheral
    next_sysclk_prescaler = sysclk_prescaler;
    if (stop_mode) begin
      next_sysclk_prescaler = 13'h0000;
    end else if (sys_tick) begin
      next_sysclk_prescaler = sysclk_prescaler + 13'h0001;
    end
    next_watch_div = watch_div;
    next_subclk_prescaler = subclk_prescaler;
    subclk_tick_o = 1'b0;
    if (watch_tick) begin
      // Runs whatever the power mode while a subclock is present
      next_watch_div = watch_div + 2'h1;
      if (watch_div == 2'h3) begin
        next_subclk_prescaler = subclk_prescaler + 5'h01;
        subclk_tick_o = 1'b1;
      end
    end
    if (tma_clear) begin
      // Software clear wins over a coincident count
      next_subclk_prescaler = 5'h00;
    end
  end

  // Prescaler registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysclk_prescaler <= 13'h0000;
      mdiv <= 7'h00;
      watch_div <= 2'h0;
      subclk_prescaler <= 5'h00;
    end else begin
      sysclk_prescaler <= next_sysclk_prescaler;
      mdiv <= next_mdiv;
      watch_div <= next_watch_div;
      subclk_prescaler <= next_subclk_prescaler;
    end
  end

  // Tap outputs come straight from counter flip-flops
  always_comb begin
    taps_o.sys = sysclk_prescaler;
    // Watch taps: undivided, /2, /4, then subclock prescaler bits
    taps_o.watch = {subclk_prescaler, watch_div, sub_prev};
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake wait sequencer
  always_comb begin
    wake_wait_select =
      system_control_one[`SYSCTL1_WAIT_MSB:`SYSCTL1_WAIT_LSB];
    // 8, 32, 128 ... 131072 states; a longer choice tolerates slow crystals
    wait_len = `WAIT_BASE << {wake_wait_select, 1'b0};
    next_wstate = wstate;
    next_wait_cnt = wait_cnt;
    wake_done_o = 1'b0;
    case (wstate)
      clkgen_pkg::WK_RUN: begin
        if (stop_mode) begin
          next_wstate = clkgen_pkg::WK_STOPPED;
        end
      end
      clkgen_pkg::WK_STOPPED: begin
        // Oscillator restarts on interrupt acceptance
        if (wake_accept_i) begin
          next_wstate = clkgen_pkg::WK_STARTUP;
        end
      end
      clkgen_pkg::WK_STARTUP: begin
        if (stb_s2) begin
          next_wstate = clkgen_pkg::WK_WAITING;
          next_wait_cnt = 18'h00000;
        end
      end
      clkgen_pkg::WK_WAITING: begin
        // Counted in system clock states, not oscillator cycles
        if (sys_tick) begin
          if (wait_cnt == wait_len - 18'h00001) begin
            next_wstate = clkgen_pkg::WK_RUN;
            wake_done_o = 1'b1;
          end else begin
            next_wait_cnt = wait_cnt + 18'h00001;
          end
        end
      end
      default: begin
        next_wstate = clkgen_pkg::WK_RUN;
      end
    endcase
    osc_run_o = (wstate != clkgen_pkg::WK_STOPPED);
    hold_idle_o = (wstate != clkgen_pkg::WK_RUN);
  end

  // Wake registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wstate <= clkgen_pkg::WK_RUN;
      wait_cnt <= 18'h00000;
    end else begin
      wstate <= next_wstate;
      wait_cnt <= next_wait_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone register file
  always_comb begin
    wr_en = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    tma_clear = wr_en & (adr_i == `OFS_TMRA_MODE) &
                dat_i[`TMRA_CLR_HI] & dat_i[`TMRA_CLR_LO];
    next_system_control_one = system_control_one;
    next_timer_a_mode_reg = timer_a_mode_reg;
    next_port_mode_reg_two = port_mode_reg_two;
    if (wr_en) begin
      case (adr_i)
        `OFS_SYSCTL1: next_system_control_one = dat_i[7:0];
        `OFS_TMRA_MODE: next_timer_a_mode_reg = dat_i[7:0];
        `OFS_PORTMODE2: next_port_mode_reg_two = dat_i[7:0];
        default: begin
          // Status and unmapped words ignore writes
          next_port_mode_reg_two = port_mode_reg_two;
        end
      endcase
    end
    next_ack = cyc_i & stb_i & ~ack_o;
    // The system prescaler has no address here
    case (adr_i)
      `OFS_SYSCTL1: next_dat = {24'h000000, system_control_one};
      `OFS_TMRA_MODE: next_dat = {24'h000000, timer_a_mode_reg};
      `OFS_PORTMODE2: next_dat = {24'h000000, port_mode_reg_two};
      `OFS_STATUS: next_dat = {16'h0000, subclk_prescaler, 3'h0, wstate,
                               osc_run_o, stop_mode, hold_idle_o, 1'b0};
      default: next_dat = 32'h00000000;
    endcase
  end

  // Register and bus flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_control_one <= `SYSCTL1_RST;
      timer_a_mode_reg <= `TMRA_RST;
      port_mode_reg_two <= `PORTMODE2_RST;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      system_control_one <= next_system_control_one;
      timer_a_mode_reg <= next_timer_a_mode_reg;
      port_mode_reg_two <= next_port_mode_reg_two;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

endmodule // clock_prescalers_and_wake_wait

// [shared/clkgen_cfg.svh]
// Offsets, field positions, reset values and counts for the clock prescaler block
`ifndef CLKGEN_CFG_SVH
`define CLKGEN_CFG_SVH
// Register byte offsets
`define OFS_SYSCTL1 8'h00
`define OFS_TMRA_MODE 8'h04
`define OFS_PORTMODE2 8'h08
`define OFS_STATUS 8'h0c
// Field positions
`define SYSCTL1_WAIT_LSB 4
`define SYSCTL1_WAIT_MSB 6
`define SYSCTL1_MDIV_LSB 0
`define SYSCTL1_MDIV_MSB 1
`define TMRA_CLR_HI 3
`define TMRA_CLR_LO 2
`define PORTMODE2_EXTSEL 7
// Reset values
`define SYSCTL1_RST 8'h70
`define TMRA_RST 8'h00
`define PORTMODE2_RST 8'h00
// Counter widths
`define SYS_PS_W 13
`define SUB_PS_W 5
`define WAIT_W 18
// Medium-speed base divide ratio (16, doubled per select step)
`define MDIV_BASE 8'h10
// Wake wait in states: 8 shifted left by twice the select value
`define WAIT_BASE 18'h00008
`endif

// [shared/clkgen_pkg.sv]
// Types shared by the clock prescaler block
package clkgen_pkg;
  // Operating mode as driven by the power-mode sequencer
  typedef enum logic [2:0] {
    MODE_ACTIVE_HS = 3'h0,
    MODE_ACTIVE_MS = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_STANDBY = 3'h3,
    MODE_WATCH = 3'h4,
    MODE_SUBACTIVE = 3'h5,
    MODE_SUBSLEEP = 3'h6
  } power_mode_t;
  // Wake sequencer states, one-hot
  typedef enum logic [3:0] {
    WK_RUN = 4'h1,
    WK_STOPPED = 4'h2,
    WK_STARTUP = 4'h4,
    WK_WAITING = 4'h8
  } wake_state_t;
  // Clock taps offered to peripherals
  typedef struct packed {
    logic [12:0] sys;   // bit n is system clock / 2^(n+1)
    logic [7:0] watch;  // bit n is watch clock / 2^n
  } clk_taps_t;
endpackage
